// ==== hw/psmc_top.v ====
// Pin state controller for external bus, debug and port pins
// Operation
// - Power-on: debug reset pulled down, rest floating
// - External reset pulls debug reset input down
// - Internal reset uses debug pin select bit
// - Bus pins are inputs after reset
// - Debug output floats in reset unless on-chip debug mode is set; it always floats at power-on
// - HALT with DMA keeps bus running
// - HALT without DMA floats address/data, separate
// - Active alternate function keeps clock output running in standby
// - Held pins keep last bus cycle level
// - Idle after T2/T3 read holds bus
// - Wait and hold request ignored when listed
`timescale 1ns/1ps
`default_nettype none
`include "psmc_defines.vh"
module psmc_top (
  input  wire        core_clk_i,
  input  wire        sys_rst_i,
  input  wire        por_active_i,
  input  wire [1:0]  rst_src_i,
  input  wire [2:0]  mode_i,
  input  wire        dma_active_i,
  input  wire        mux_bus_i,
  input  wire        bus_en_i,
  input  wire        idle_after_read_i,
  input  wire        debug_pin_select_bit_i,
  input  wire        ocd_mode_i,
  input  wire        alt_func_i,
  input  wire [15:0] core_ad_out_i,
  input  wire        core_ad_oe_i,
  input  wire [21:0] core_addr_i,
  input  wire        core_rd_i,
  input  wire        core_wr0_i,
  input  wire        core_wr1_i,
  input  wire        core_address_strobe_out_i,
  input  wire        core_dbg_out_i,
  input  wire        wait_pin_i,
  input  wire        hold_request_in_i,
  output wire        wait_o,
  output wire        hold_req_o,
  output reg         debug_reset_in_pd_o,
  output reg  [15:0] addr_data_bus_o,
  output reg  [15:0] addr_data_bus_oe_n_o,
  output reg  [21:0] address_bus_o,
  output reg  [21:0] address_bus_oe_n_o,
  output reg         read_strobe_n_o,
  output reg         write_strobe_low_byte_n_o,
  output reg         write_strobe_high_byte_n_o,
  output reg         address_strobe_out_o,
  output reg         strobe_oe_n_o,
  output reg         hold_acknowledge_out_n_o,
  output reg         hold_ack_oe_n_o,
  output reg         system_clock_out_o,
  output reg         debug_serial_out_o,
  output reg         debug_serial_out_oe_n_o
);
  // ==========================================================
  // Pin input synchronisation
  wire [1:0] pin_sync;
  psmc_sync #(.W(2)) u_psmc_sync (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .async_i    ({wait_pin_i, hold_request_in_i}),
    .sync_o     (pin_sync)
  );

  // Mode decode
  wire is_halt  = (mode_i == `PSMC_MODE_HALT);
  wire is_idle  = (mode_i == `PSMC_MODE_IDLE);
  wire is_stop  = (mode_i == `PSMC_MODE_STOP);
  wire is_bidle = (mode_i == `PSMC_MODE_BIDLE);
  wire is_hold  = (mode_i == `PSMC_MODE_HOLD);
  wire is_run   = (mode_i == `PSMC_MODE_RUN);
  // Reset sources; power-on outranks both, external outranks internal
  wire ext_rst  = (rst_src_i == `PSMC_RST_EXT);
  wire int_rst  = (rst_src_i == `PSMC_RST_INT);
  wire in_rst   = por_active_i | (rst_src_i != `PSMC_RST_NONE);

  // Left combinational: the pins have already passed two flops
  // Wait sampled only when running, during HALT with DMA, or on an unused mode code
  assign wait_o = (is_idle | is_stop | is_bidle | is_hold |
                   (is_halt & ~dma_active_i)) ? 1'b0 : pin_sync[1];
  // Hold request unsampled in standby and idle states
  assign hold_req_o = (is_idle | is_stop | is_bidle) ? 1'b0 :
                      pin_sync[0];

  // ==========================================================
  // Last bus cycle capture for held pins
  reg [15:0] held_ad_ff;
  reg [21:0] held_addr_ff;
  reg        bus_live;
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      held_ad_ff   <= 16'h0000;
      held_addr_ff <= 22'h000000;
    end else if (bus_live) begin
      held_ad_ff   <= core_ad_out_i;
      held_addr_ff <= core_addr_i;
    end
  end

  // Debug output level from the last run cycle. It is kept apart
  // from the bus capture because the debug pin works even with the
  // external bus left in port mode.
  reg held_dbg_ff;
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      held_dbg_ff <= 1'b0;
    end else if (~in_rst & is_run) begin
      held_dbg_ff <= core_dbg_out_i;
    end
  end

  // ==========================================================
  // Clock output divider; runs whenever not in reset or deep standby.
  // The pin register loads the same next value as the divider, so
  // the pin reacts to a mode change one edge later like the others.
  reg  clk_div_ff;
  wire clk_run = ~in_rst & ~is_idle & ~is_stop;
  // An alternate function keeps it up in standby, never in reset
  wire alt_clk = alt_func_i & ~in_rst;
  wire nxt_clk = (clk_run | alt_clk) ? ~clk_div_ff : 1'b0;
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      clk_div_ff <= 1'b0;
    end else begin
      clk_div_ff <= nxt_clk;
    end
  end

  // ==========================================================
  // Pin state decode, registered so pin outputs come from flops
  reg        nxt_pd;
  reg [15:0] nxt_ad;
  reg [15:0] nxt_ad_oe_n;
  reg [21:0] nxt_addr;
  reg [21:0] nxt_addr_oe_n;
  reg        nxt_rd_n;
  reg        nxt_wr0_n;
  reg        nxt_wr1_n;
  reg        nxt_address_strobe_out;
  reg        nxt_strb_oe_n;
  reg        nxt_hak_n;
  reg        nxt_hak_oe_n;
  reg        nxt_dbg;
  reg        nxt_dbg_oe_n;
  always @* begin
    bus_live      = 1'b0;
    nxt_pd        = 1'b0;
    nxt_ad        = held_ad_ff;
    nxt_ad_oe_n   = 16'hffff;
    nxt_addr      = held_addr_ff;
    nxt_addr_oe_n = 22'h3fffff;
    nxt_rd_n      = 1'b1;
    nxt_wr0_n     = 1'b1;
    nxt_wr1_n     = 1'b1;
    nxt_address_strobe_out      = 1'b1;
    nxt_strb_oe_n = 1'b1;
    nxt_hak_n     = 1'b1;
    nxt_hak_oe_n  = 1'b1;
    nxt_dbg       = core_dbg_out_i;
    nxt_dbg_oe_n  = 1'b0;
    if (por_active_i) begin
      nxt_pd       = 1'b1;
      nxt_dbg_oe_n = 1'b1;
    end else if (ext_rst) begin
      nxt_pd       = 1'b1;
      nxt_dbg_oe_n = ~ocd_mode_i;
    end else if (int_rst) begin
      nxt_pd       = debug_pin_select_bit_i;
      nxt_dbg_oe_n = ~ocd_mode_i;
    end else if (~bus_en_i) begin
      // Port mode: bus pins stay inputs until software enables
      nxt_dbg_oe_n = 1'b0;
    end else begin
      // Bus configured: control and address pins are driven
      nxt_strb_oe_n = 1'b0;
      nxt_hak_oe_n  = 1'b0;
      nxt_addr_oe_n = 22'h000000;
      case (mode_i)
        // Normal operation: the core drives every bus pin
        `PSMC_MODE_RUN: begin
          bus_live    = 1'b1;
          nxt_ad      = core_ad_out_i;
          nxt_ad_oe_n = {16{~core_ad_oe_i}};
          nxt_addr    = core_addr_i;
          nxt_rd_n    = core_rd_i;
          nxt_wr0_n   = core_wr0_i;
          nxt_wr1_n   = core_wr1_i;
          nxt_address_strobe_out    = core_address_strobe_out_i;
        end
        `PSMC_MODE_HALT: begin
          if (dma_active_i) begin
            bus_live    = 1'b1;
            nxt_ad      = core_ad_out_i;
            nxt_ad_oe_n = {16{~core_ad_oe_i}};
            nxt_addr    = core_addr_i;
            nxt_rd_n    = core_rd_i;
            nxt_wr0_n   = core_wr0_i;
            nxt_wr1_n   = core_wr1_i;
            nxt_address_strobe_out    = core_address_strobe_out_i;
          end else begin
            // Multiplexed level is undefined; we keep it floating too
            nxt_ad_oe_n = 16'hffff;
          end
        end
        // Deep standby: strobes stay driven high, data floats
        `PSMC_MODE_IDLE, `PSMC_MODE_STOP: begin
          nxt_ad_oe_n = 16'hffff;
        end
        `PSMC_MODE_BIDLE: begin
          // Hold bus levels after T2 (separate) or T3 read (mux)
          if (~mux_bus_i | idle_after_read_i) begin
            nxt_ad_oe_n = 16'h0000;
          end
        end
        // External master owns the bus; let go of all of it
        `PSMC_MODE_HOLD: begin
          nxt_ad_oe_n   = 16'hffff;
          nxt_addr_oe_n = 22'h3fffff;
          nxt_strb_oe_n = 1'b1;
          nxt_hak_n     = 1'b0;
        end
        // Unused codes float the data pins as the safe choice
        default: begin
          nxt_ad_oe_n = 16'hffff;
        end
      endcase
    end
    // Standby and idle hold the debug pin unless debug owns it
    if (~in_rst & ~is_run & ~ocd_mode_i) begin
      nxt_dbg = held_dbg_ff;
    end
  end

  // ==========================================================
  // Debug pins; the pull-down holds in power-on and external reset, and in internal reset when the select bit is set
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      debug_reset_in_pd_o     <= 1'b1;
      debug_serial_out_o      <= 1'b0;
      debug_serial_out_oe_n_o <= 1'b1;
    end else begin
      debug_reset_in_pd_o     <= nxt_pd;
      debug_serial_out_o      <= nxt_dbg;
      debug_serial_out_oe_n_o <= nxt_dbg_oe_n;
    end
  end

  // ==========================================================
  // Address and data pins; released until the decode drives them
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      addr_data_bus_o      <= 16'h0000;
      addr_data_bus_oe_n_o <= 16'hffff;
      address_bus_o        <= 22'h000000;
      address_bus_oe_n_o   <= 22'h3fffff;
    end else begin
      addr_data_bus_o      <= nxt_ad;
      addr_data_bus_oe_n_o <= nxt_ad_oe_n;
      address_bus_o        <= nxt_addr;
      address_bus_oe_n_o   <= nxt_addr_oe_n;
    end
  end

  // ==========================================================
  // Bus strobes; inactive high so a released bus reads as idle
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      read_strobe_n_o            <= 1'b1;
      write_strobe_low_byte_n_o  <= 1'b1;
      write_strobe_high_byte_n_o <= 1'b1;
      address_strobe_out_o       <= 1'b1;
      strobe_oe_n_o              <= 1'b1;
    end else begin
      read_strobe_n_o            <= nxt_rd_n;
      write_strobe_low_byte_n_o  <= nxt_wr0_n;
      write_strobe_high_byte_n_o <= nxt_wr1_n;
      address_strobe_out_o       <= nxt_address_strobe_out;
      strobe_oe_n_o              <= nxt_strb_oe_n;
    end
  end

  // ==========================================================
  // Hold acknowledge; a plain level, no separate handshake
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      hold_acknowledge_out_n_o <= 1'b1;
      hold_ack_oe_n_o          <= 1'b1;
    end else begin
      hold_acknowledge_out_n_o <= nxt_hak_n;
      hold_ack_oe_n_o          <= nxt_hak_oe_n;
    end
  end

  // ==========================================================
  // Clock output pin; a copy of the divider's next value
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      system_clock_out_o <= 1'b0;
    end else begin
      system_clock_out_o <= nxt_clk;
    end
  end
endmodule
`default_nettype wire

// ==== hw/psmc_defines.vh ====
// Constants for the pin state mode controller
`ifndef PSMC_DEFINES_VH
`define PSMC_DEFINES_VH
// Clock period and power-on interval
`define PSMC_CLK_NS        25
`define PSMC_POR_US        1000
`define PSMC_POR_CYC       ((`PSMC_POR_US * 1000) / `PSMC_CLK_NS)
// Operating mode encoding on mode_i
`define PSMC_MODE_RUN      3'h0
`define PSMC_MODE_HALT     3'h1
`define PSMC_MODE_IDLE     3'h2
`define PSMC_MODE_STOP     3'h3
`define PSMC_MODE_BIDLE    3'h4
`define PSMC_MODE_HOLD     3'h5
// Reset source encoding
`define PSMC_RST_NONE      2'h0
`define PSMC_RST_EXT       2'h1
`define PSMC_RST_INT       2'h2
// Clock output divider ratio (half period in cycles)
`define PSMC_CLKDIV_HALF   1'b1
`endif

// ==== hw/psmc_sync.v ====
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module psmc_sync #(
  parameter W = 1
) (
  input  wire         core_clk_i,
  input  wire         sys_rst_i,
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;
  // ==========================================================
  // Synchroniser stages; first stage feeds only the second
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end
  assign sync_o = sync_ff;
endmodule
`default_nettype wire

// ==== dv/psmc_monitor.sv ====
// Checker on pin states across modes and resets
`timescale 1ns/1ps
`default_nettype none
`include "psmc_defines.vh"
module psmc_monitor (
  input wire logic        core_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        por_active_i,
  input wire logic [1:0]  rst_src_i,
  input wire logic [2:0]  mode_i,
  input wire logic        dma_active_i,
  input wire logic        mux_bus_i,
  input wire logic        bus_en_i,
  input wire logic        alt_func_i,
  input wire logic        wait_o,
  input wire logic        hold_req_o,
  input wire logic        debug_reset_in_pd_o,
  input wire logic [15:0] addr_data_bus_oe_n_o,
  input wire logic [21:0] address_bus_o,
  input wire logic        strobe_oe_n_o,
  input wire logic        hold_acknowledge_out_n_o,
  input wire logic        system_clock_out_o
);
  wire logic live;
  // No power-on or reset source in force
  assign live = !por_active_i && rst_src_i == `PSMC_RST_NONE;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // ========================================
  // Pin states one cycle after their cause; hold request and wait in the same cycle
  property p_por;
    por_active_i |=> debug_reset_in_pd_o && &addr_data_bus_oe_n_o;
  endproperty
  a_por: assert property (p_por) else $error("power-on pins");
  property p_hold;
    live && bus_en_i && mode_i == `PSMC_MODE_HOLD
      |=> !hold_acknowledge_out_n_o
      && strobe_oe_n_o && &addr_data_bus_oe_n_o;
  endproperty
  a_hold: assert property (p_hold) else $error("hold pins");
  property p_clk_low;
    live && !alt_func_i && mode_i inside {`PSMC_MODE_IDLE, `PSMC_MODE_STOP}
      |=> !system_clock_out_o;
  endproperty
  a_clk_low: assert property (p_clk_low) else $error("clock low");
  property p_clk_run;
    (live && mode_i == `PSMC_MODE_HALT) [*2] |=> $changed(system_clock_out_o);
  endproperty
  a_clk_run: assert property (p_clk_run) else $error("clock run");
  property p_hreq;
    mode_i inside {`PSMC_MODE_IDLE, `PSMC_MODE_STOP, `PSMC_MODE_BIDLE}
      |-> !hold_req_o;
  endproperty
  a_hreq: assert property (p_hreq) else $error("hold request");
  // Wait is sampled only in run, while DMA owns the bus, or on an unused mode code
  property p_wait;
    mode_i inside {`PSMC_MODE_IDLE, `PSMC_MODE_STOP, `PSMC_MODE_BIDLE,
      `PSMC_MODE_HOLD} || mode_i == `PSMC_MODE_HALT && !dma_active_i
      |-> !wait_o;
  endproperty
  a_wait: assert property (p_wait) else $error("wait input");
  property p_halt_float;
    live && mode_i == `PSMC_MODE_HALT && !dma_active_i && !mux_bus_i
      |=> &addr_data_bus_oe_n_o;
  endproperty
  a_halt_float: assert property (p_halt_float) else $error("halt");
  property p_idle_held;
    (live && mode_i == `PSMC_MODE_RUN && bus_en_i) ##1
      (live && mode_i == `PSMC_MODE_BIDLE && !mux_bus_i)
      |=> $stable(address_bus_o);
  endproperty
  a_idle_held: assert property (p_idle_held) else $error("held");
  c_hold: cover property (live && mode_i == `PSMC_MODE_HOLD);
  c_int: cover property (rst_src_i == `PSMC_RST_INT);
  c_dma: cover property (mode_i == `PSMC_MODE_HALT && dma_active_i);
  c_mux: cover property (live && mode_i == `PSMC_MODE_BIDLE && mux_bus_i);
endmodule
bind psmc_top psmc_monitor u_psmc_monitor (.core_clk_i, .sys_rst_i,
  .por_active_i, .rst_src_i, .mode_i, .dma_active_i, .mux_bus_i, .bus_en_i,
  .alt_func_i, .wait_o, .hold_req_o, .debug_reset_in_pd_o,
  .addr_data_bus_oe_n_o, .address_bus_o, .strobe_oe_n_o,
  .hold_acknowledge_out_n_o, .system_clock_out_o);
`default_nettype wire

// ==== dv/psmc_bus_partner.sv ====
// Model of the outside bus master: hold request and wait pins
`timescale 1ns/1ps
`default_nettype none
module psmc_bus_partner (
  input  wire logic core_clk_i,
  input  wire logic want_bus_i,
  input  wire logic stall_i,
  output var logic  hold_request_in_o = 1'h0,
  output var logic  wait_pin_o = 1'h0
);
  // Request stays up for as long as the master wants the bus
  always @(posedge core_clk_i) begin
    hold_request_in_o <= want_bus_i;
    wait_pin_o <= stall_i;
  end
endmodule
`default_nettype wire

// ==== dv/psmc_tb_top.sv ====
// Bench driving the pin state controller through modes
`timescale 1ns/1ps
`default_nettype none
`include "psmc_defines.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  n_mismatch++; $display("BAD %s exp %h got %h", n, e, g); end end
module psmc_tb_top;
  logic core_clk_i, sys_rst_i, por_active_i, dma_active_i, mux_bus_i;
  logic bus_en_i, idle_after_read_i, debug_pin_select_bit_i, ocd_mode_i;
  logic alt_func_i, core_ad_oe_i, core_rd_i, core_wr0_i, core_wr1_i;
  logic core_address_strobe_out_i, core_dbg_out_i, want_bus, stall, c0;
  logic [1:0] rst_src_i;
  logic [2:0] mode_i;
  logic [15:0] core_ad_out_i;
  logic [21:0] core_addr_i;
  wire logic wait_pin_i, hold_request_in_i, wait_o, hold_req_o;
  wire logic debug_reset_in_pd_o, read_strobe_n_o, address_strobe_out_o;
  wire logic write_strobe_low_byte_n_o, write_strobe_high_byte_n_o;
  wire logic strobe_oe_n_o, hold_acknowledge_out_n_o, hold_ack_oe_n_o;
  wire logic system_clock_out_o, debug_serial_out_o;
  wire logic debug_serial_out_oe_n_o;
  wire logic [15:0] addr_data_bus_o, addr_data_bus_oe_n_o;
  wire logic [21:0] address_bus_o, address_bus_oe_n_o;
  int n_mismatch = 0;
  int samples_checked = 0;
  psmc_top u_psmc_top (.*);
  psmc_bus_partner u_psmc_bus_partner (.core_clk_i, .want_bus_i(want_bus),
    .stall_i(stall), .hold_request_in_o(hold_request_in_i),
    .wait_pin_o(wait_pin_i));
  // 40 MHz core clock
  always #12.5 core_clk_i = ~core_clk_i;
  // ========================================
  // Scenarios; outputs land one edge after inputs are taken
  task settle;
    repeat (2) @(negedge core_clk_i);
  endtask
  task t_reset;
    @(posedge core_clk_i);
    por_active_i <= 1'h1;
    settle;
    `CHK("por_pd", 1'h1, debug_reset_in_pd_o)
    `CHK("por_ad", 16'hffff, addr_data_bus_oe_n_o)
    @(posedge core_clk_i);
    por_active_i <= 1'h0;
    rst_src_i <= `PSMC_RST_EXT;
    settle;
    `CHK("ext_pd", 1'h1, debug_reset_in_pd_o)
    `CHK("ext_a", 22'h3fffff, address_bus_oe_n_o)
    `CHK("ext_dbg", 1'h1, debug_serial_out_oe_n_o)
    @(posedge core_clk_i);
    rst_src_i <= `PSMC_RST_INT;
    ocd_mode_i <= 1'h1;
    core_dbg_out_i <= 1'h1;
    settle;
    `CHK("int_pd0", 1'h0, debug_reset_in_pd_o)
    `CHK("ocd_dbg", 1'h0, debug_serial_out_oe_n_o)
    `CHK("ocd_do", 1'h1, debug_serial_out_o)
    @(posedge core_clk_i);
    debug_pin_select_bit_i <= 1'h1;
    settle;
    `CHK("int_pd1", 1'h1, debug_reset_in_pd_o)
    @(posedge core_clk_i);
    rst_src_i <= `PSMC_RST_NONE;
  endtask
  // New address in the idle state must not reach the pins
  task t_bidle;
    @(posedge core_clk_i);
    core_addr_i <= 22'h012345;
    settle;
    @(posedge core_clk_i);
    mode_i <= `PSMC_MODE_BIDLE;
    idle_after_read_i <= 1'h1;
    core_addr_i <= 22'h0abcde;
    {core_rd_i, core_wr0_i, core_wr1_i, core_address_strobe_out_i} <= 4'h0;
    settle;
    `CHK("idle_a", 22'h012345, address_bus_o)
    `CHK("idle_ad", 16'h0000, addr_data_bus_oe_n_o)
    `CHK("idle_rd", 1'h1, read_strobe_n_o)
    `CHK("idle_as", 1'h1, address_strobe_out_o)
    // Multiplexed bus with no read before the idle state floats
    @(posedge core_clk_i);
    mux_bus_i <= 1'h1;
    idle_after_read_i <= 1'h0;
    settle;
    `CHK("idle_mux", 16'hffff, addr_data_bus_oe_n_o)
    @(posedge core_clk_i);
    mux_bus_i <= 1'h0;
  endtask
  task t_halt;
    @(posedge core_clk_i);
    mode_i <= `PSMC_MODE_HALT;
    settle;
    c0 = system_clock_out_o;
    @(negedge core_clk_i);
    `CHK("halt_clk", 1'h1, c0 ^ system_clock_out_o)
    `CHK("halt_ad", 16'hffff, addr_data_bus_oe_n_o)
    @(posedge core_clk_i);
    dma_active_i <= 1'h1;
    core_ad_oe_i <= 1'h1;
    core_ad_out_i <= 16'h5a3c;
    stall <= 1'h1;
    repeat (4) @(negedge core_clk_i);
    `CHK("dma_ad", 16'h5a3c, addr_data_bus_o)
    `CHK("dma_oe", 16'h0000, addr_data_bus_oe_n_o)
    `CHK("dma_wait", 1'h1, wait_o)
    @(posedge core_clk_i);
    dma_active_i <= 1'h0;
  endtask
  task t_hold;
    @(posedge core_clk_i);
    mode_i <= `PSMC_MODE_HOLD;
    want_bus <= 1'h1;
    repeat (4) @(negedge core_clk_i);
    `CHK("hold_ack", 1'h0, hold_acknowledge_out_n_o)
    `CHK("hold_aoe", 1'h0, hold_ack_oe_n_o)
    `CHK("hold_st", 1'h1, strobe_oe_n_o)
    `CHK("hold_rq", 1'h1, hold_req_o)
    `CHK("hold_wait", 1'h0, wait_o)
  endtask
  // Request and stall stay up from the master; all must be ignored
  task t_standby;
    static logic [2:0] m [4] = '{3'h2, 3'h3, 3'h4, 3'h2};
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk_i);
      mode_i <= m[i];
      alt_func_i <= (i == 3);
      settle;
      c0 = system_clock_out_o;
      @(negedge core_clk_i);
      `CHK("sb_rq", 1'h0, hold_req_o)
      `CHK("sb_wait", 1'h0, wait_o)
      `CHK("sb_wr", 1'h1, write_strobe_low_byte_n_o)
      `CHK("sb_wr1", 1'h1, write_strobe_high_byte_n_o)
      `CHK("sb_as", 1'h1, address_strobe_out_o)
      `CHK("sb_clk", (i > 1) ? 2'h3 : 2'h0,
        {c0 | system_clock_out_o, c0 ^ system_clock_out_o})
    end
  endtask
  task stop_test;
    $display("compared %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    {core_clk_i, por_active_i, dma_active_i, mux_bus_i, idle_after_read_i,
      debug_pin_select_bit_i, ocd_mode_i, alt_func_i, core_ad_oe_i,
      core_dbg_out_i, want_bus, stall} = '0;
    {sys_rst_i, bus_en_i, core_rd_i, core_wr0_i, core_wr1_i, core_address_strobe_out_i} = '1;
    {rst_src_i, mode_i, core_ad_out_i, core_addr_i} = '0;
    repeat (10) @(posedge core_clk_i);
    sys_rst_i <= 1'h0;
    t_reset;
    t_bidle;
    t_halt;
    t_hold;
    t_standby;
    stop_test;
  end
  // Cuts a hung run short
  initial begin
    #50us;
    n_mismatch++;
    stop_test;
  end
endmodule
`default_nettype wire
